// ### scm_clock_manager.sv
// system clock manager: source control, prescaler, derived clock enables
// Functional notes
// - core clock stops while sleep is asserted
// - peripheral clock drives timers, serial, interrupts
// - flash interface tick is fast RC over 32
// - async timer clocked from low-speed crystal input
// - watchdog clock slow RC or fast RC/16
// - watchdog defaults to slow RC after reset
// - bits 0..3 enable the four sources
// - reset runs fast RC divided by eight
// - bits 6:5 select main source immediately
// - source control writes only in 6-cycle window
// - prescaler output clocks core and peripherals
// - divider change glitch-free, at period end
// - divider writes only in 4-cycle window
// - factory trims load after reset
// - user trim writes keep factory copy; reload restores
// - divider codes 0..8 divide by powers of two
// - bit 4 selects watchdog clock source
module scm_clock_manager (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    output logic [7:0] io_rdata,
    input wire logic fast_rc_osc,
    input wire logic slow_rc_osc,
    input wire logic hs_xtal,
    input wire logic ls_xtal,
    input wire logic sleep_req,
    input wire logic peri_halt,
    input wire logic [7:0] cfg_fast_trim,
    input wire logic [7:0] cfg_slow_trim,
    input wire logic cfg_reload,
    output logic core_clk_en,
    output logic peri_clk_en,
    output logic flash_if_clock,
    output logic async_timer_tick,
    output logic watchdog_clock,
    output logic [3:0] osc_enable,
    output logic [1:0] sys_clk_out_en,
    output logic [7:0] fast_osc_trim,
    output logic [7:0] slow_osc_trim
);
    logic [6:0] src_ctrl;
    logic [6:0] next_src_ctrl;
    logic [2:0] src_win;
    logic [2:0] next_src_win;
    logic [3:0] divider_select;
    logic [3:0] next_divider_select;
    logic [1:0] clk_out_sel;
    logic [1:0] next_clk_out_sel;
    logic [2:0] div_win;
    logic [2:0] next_div_win;
    logic [7:0] next_fast_osc_trim;
    logic [7:0] next_slow_osc_trim;
    logic trims_loaded;
    logic next_trims_loaded;
    logic [7:0] next_io_rdata;
    logic [4:0] flash_cnt;
    logic [4:0] next_flash_cnt;
    logic [3:0] wdt_cnt;
    logic [3:0] next_wdt_cnt;
    logic flash_tick;
    logic next_flash_tick;
    logic wdt_tick;
    logic next_wdt_tick;
    logic async_tick;
    logic next_async_tick;
    logic [3:0] osc_rise;
    logic [3:0] src_live;
    logic sel_tick;
    scm_pkg::scm_sel_t main_sel;

    scm_tick_if tk ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    scm_edge_sync #(
        .WIDTH(scm_pkg::NUM_SOURCES)
    ) u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .pin({ls_xtal, hs_xtal, slow_rc_osc, fast_rc_osc}),
        .rise(osc_rise)
    );

    scm_prescaler #(
        .CNT_W(8)
    ) u_presc (
        .mclk(mclk),
        .rstn(rstn),
        .tk(tk.presc)
    );

    // a disabled source contributes no edges
    assign src_live = osc_rise & src_ctrl[3:0];
    assign main_sel = scm_pkg::scm_sel_t'(src_ctrl[scm_pkg::SRC_SEL_HI:scm_pkg::SRC_SEL_LO]);

    // no stability check: an unstarted crystal simply yields no ticks
    always_comb begin
        case (main_sel)
            scm_pkg::SCM_SEL_FAST_RC: sel_tick = src_live[scm_pkg::SRC_FAST_EN_BIT];
            scm_pkg::SCM_SEL_HS_XTAL: sel_tick = src_live[scm_pkg::SRC_HS_EN_BIT];
            scm_pkg::SCM_SEL_SLOW_RC: sel_tick = src_live[scm_pkg::SRC_SLOW_EN_BIT];
            scm_pkg::SCM_SEL_LS_XTAL: sel_tick = src_live[scm_pkg::SRC_LS_EN_BIT];
            default: sel_tick = 1'b0;
        endcase
    end

    assign tk.src_tick = sel_tick;
    assign tk.div_sel = divider_select;

    // one prescaled tick feeds both core and peripherals
    assign core_clk_en = tk.sys_tick & ~sleep_req;
    assign peri_clk_en = tk.sys_tick & ~peri_halt;
    assign flash_if_clock = flash_tick;
    assign async_timer_tick = async_tick;
    assign watchdog_clock = wdt_tick;
    assign osc_enable = src_ctrl[3:0];
    assign sys_clk_out_en = clk_out_sel;

    // register writes and timed-access windows
    always_comb begin
        next_src_ctrl = src_ctrl;
        next_src_win = (src_win != 3'h0) ? src_win - 3'h1 : 3'h0;
        next_divider_select = divider_select;
        next_clk_out_sel = clk_out_sel;
        next_div_win = (div_win != 3'h0) ? div_win - 3'h1 : 3'h0;
        next_fast_osc_trim = fast_osc_trim;
        next_slow_osc_trim = slow_osc_trim;
        next_trims_loaded = 1'b1;
        if (io_we && hit(io_addr, scm_pkg::ADDR_SRC_CTRL)) begin
            if (src_win != 3'h0) begin
                next_src_ctrl = io_wdata[6:0];
                next_src_win = 3'h0;
            end else if (io_wdata[scm_pkg::SRC_CHANGE_BIT]) begin
                next_src_win = scm_pkg::SRC_WINDOW_CYCLES;
            end
        end
        if (io_we && hit(io_addr, scm_pkg::ADDR_DIVIDER)) begin
            if (io_wdata == scm_pkg::DIV_OPEN_VALUE) begin
                next_div_win = scm_pkg::DIV_WINDOW_CYCLES;
            end else if (div_win != 3'h0 && !io_wdata[scm_pkg::DIV_CHANGE_BIT]) begin
                next_div_win = 3'h0;
                next_clk_out_sel = io_wdata[scm_pkg::DIV_OUT1_BIT:scm_pkg::DIV_OUT0_BIT];
                // reserved codes leave the running divider untouched
                if (io_wdata[3:0] <= scm_pkg::DIV_SEL_MAX) begin
                    next_divider_select = io_wdata[3:0];
                end
            end
        end
        if (io_we && hit(io_addr, scm_pkg::ADDR_FAST_TRIM)) begin
            next_fast_osc_trim = io_wdata;
        end
        if (io_we && hit(io_addr, scm_pkg::ADDR_SLOW_TRIM)) begin
            next_slow_osc_trim = io_wdata;
        end
        // factory values are only copied, never overwritten here
        if (!trims_loaded || cfg_reload) begin
            next_fast_osc_trim = cfg_fast_trim;
            next_slow_osc_trim = cfg_slow_trim;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            src_ctrl <= scm_pkg::SRC_CTRL_RESET;
            src_win <= 3'h0;
            divider_select <= scm_pkg::DIV_SEL_RESET;
            clk_out_sel <= 2'h0;
            div_win <= 3'h0;
            fast_osc_trim <= 8'h00;
            slow_osc_trim <= 8'h00;
            trims_loaded <= 1'b0;
        end else begin
            src_ctrl <= next_src_ctrl;
            src_win <= next_src_win;
            divider_select <= next_divider_select;
            clk_out_sel <= next_clk_out_sel;
            div_win <= next_div_win;
            fast_osc_trim <= next_fast_osc_trim;
            slow_osc_trim <= next_slow_osc_trim;
            trims_loaded <= next_trims_loaded;
        end
    end

    // read data, registered one cycle after the strobe
    always_comb begin
        next_io_rdata = io_rdata;
        if (io_re) begin
            case (io_addr)
                scm_pkg::ADDR_SRC_CTRL: next_io_rdata = {src_win != 3'h0, src_ctrl};
                scm_pkg::ADDR_DIVIDER: next_io_rdata = {div_win != 3'h0, clk_out_sel, 1'b0,
                                                        divider_select};
                scm_pkg::ADDR_FAST_TRIM: next_io_rdata = fast_osc_trim;
                scm_pkg::ADDR_SLOW_TRIM: next_io_rdata = slow_osc_trim;
                default: next_io_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= 8'h00;
        end else begin
            io_rdata <= next_io_rdata;
        end
    end

    // derived clocks from fixed dividers; they ignore the prescaler so
    // flash timing and watchdog keep their rate across divider changes
    always_comb begin
        next_flash_cnt = flash_cnt;
        next_flash_tick = 1'b0;
        next_wdt_cnt = wdt_cnt;
        next_wdt_tick = 1'b0;
        if (src_live[scm_pkg::SRC_FAST_EN_BIT]) begin
            next_flash_cnt = flash_cnt + 5'h1;
            next_flash_tick = (flash_cnt == 5'(scm_pkg::FLASH_IF_DIV - 1));
            next_wdt_cnt = wdt_cnt + 4'h1;
        end
        if (src_ctrl[scm_pkg::SRC_WDT_SEL_BIT]) begin
            next_wdt_tick = src_live[scm_pkg::SRC_SLOW_EN_BIT];
        end else begin
            next_wdt_tick = src_live[scm_pkg::SRC_FAST_EN_BIT]
                            && (wdt_cnt == 4'(scm_pkg::WDT_FAST_DIV - 1));
        end
        // async timer follows the crystal even while the core sleeps
        next_async_tick = src_live[scm_pkg::SRC_LS_EN_BIT];
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flash_cnt <= 5'h00;
            flash_tick <= 1'b0;
            wdt_cnt <= 4'h0;
            wdt_tick <= 1'b0;
            async_tick <= 1'b0;
        end else begin
            flash_cnt <= next_flash_cnt;
            flash_tick <= next_flash_tick;
            wdt_cnt <= next_wdt_cnt;
            wdt_tick <= next_wdt_tick;
            async_tick <= next_async_tick;
        end
    end
endmodule

// ### scm_pkg.sv
// constants shared by the system clock manager files
package scm_pkg;
    localparam logic [7:0] ADDR_SRC_CTRL = 8'hf2;
    localparam logic [7:0] ADDR_DIVIDER = 8'h61;
    localparam logic [7:0] ADDR_FAST_TRIM = 8'h66;
    localparam logic [7:0] ADDR_SLOW_TRIM = 8'h67;
    localparam int SRC_FAST_EN_BIT = 0;
    localparam int SRC_SLOW_EN_BIT = 1;
    localparam int SRC_HS_EN_BIT = 2;
    localparam int SRC_LS_EN_BIT = 3;
    localparam int SRC_WDT_SEL_BIT = 4;
    localparam int SRC_SEL_LO = 5;
    localparam int SRC_SEL_HI = 6;
    localparam int SRC_CHANGE_BIT = 7;
    localparam int DIV_CHANGE_BIT = 7;
    localparam int DIV_OUT0_BIT = 5;
    localparam int DIV_OUT1_BIT = 6;
    localparam logic [6:0] SRC_CTRL_RESET = 7'h13;
    localparam logic [3:0] DIV_SEL_RESET = 4'h3;
    localparam logic [3:0] DIV_SEL_MAX = 4'h8;
    localparam logic [7:0] DIV_OPEN_VALUE = 8'h80;
    localparam logic [2:0] SRC_WINDOW_CYCLES = 3'h6;
    localparam logic [2:0] DIV_WINDOW_CYCLES = 3'h4;
    localparam int FLASH_IF_DIV = 32;
    localparam int WDT_FAST_DIV = 16;
    localparam int NUM_SOURCES = 4;
    typedef enum logic [1:0] {
        SCM_SEL_FAST_RC,
        SCM_SEL_HS_XTAL,
        SCM_SEL_SLOW_RC,
        SCM_SEL_LS_XTAL
    } scm_sel_t;
endpackage

// ### scm_tick_if.sv
// carrier between the register block and the prescaler
interface scm_tick_if;
    logic src_tick;
    logic [3:0] div_sel;
    logic sys_tick;
    modport ctrl (output src_tick, output div_sel, input sys_tick);
    modport presc (input src_tick, input div_sel, output sys_tick);
endinterface

// ### scm_edge_sync.sv
// two-stage synchronisers and rising-edge pulses for oscillator pins
module scm_edge_sync #(
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;

    // refused at elaboration, before any logic is built
    if (WIDTH < 1) begin : g_bad_width
        $error("scm_edge_sync: WIDTH must be positive");
    end

    // edge detector reads only the second stage
    for (genvar i = 0; i < WIDTH; i++) begin : g_ch
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                meta[i] <= 1'b0;
                sync[i] <= 1'b0;
                prev[i] <= 1'b0;
            end else begin
                meta[i] <= pin[i];
                sync[i] <= meta[i];
                prev[i] <= sync[i];
            end
        end
        assign rise[i] = sync[i] & ~prev[i];
    end
endmodule

// ### scm_prescaler.sv
// power-of-two prescaler on source ticks, changes only at period end
module scm_prescaler #(
    parameter int CNT_W = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    scm_tick_if.presc tk
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [3:0] cur_sel;
    logic [3:0] next_cur_sel;
    logic tick;
    logic next_tick;
    logic [CNT_W-1:0] last;

    // refused at elaboration, before any logic is built
    if (CNT_W < 8) begin : g_bad_width
        $error("scm_prescaler: CNT_W must hold divide by 256");
    end

    assign last = CNT_W'((9'h1 << cur_sel) - 9'h1);
    assign tk.sys_tick = tick;

    // the new divider is taken only when the running period ends, so no
    // short period can appear between old and new rates
    always_comb begin
        next_cnt = cnt;
        next_cur_sel = cur_sel;
        next_tick = 1'b0;
        if (tk.src_tick) begin
            if (cnt >= last) begin
                next_cnt = '0;
                next_tick = 1'b1;
                next_cur_sel = tk.div_sel;
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            cur_sel <= scm_pkg::DIV_SEL_RESET;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            cur_sel <= next_cur_sel;
            tick <= next_tick;
        end
    end
endmodule

// ### scm_clock_manager_sva.sv
// port-level checker for the system clock manager
module scm_chk (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] io_addr,
    input wire logic io_we,
    input wire logic sleep_req,
    input wire logic peri_halt,
    input wire logic cfg_reload,
    input logic core_clk_en,
    input logic peri_clk_en,
    input logic flash_if_clock,
    input logic async_timer_tick,
    input logic [3:0] osc_enable,
    input logic [1:0] sys_clk_out_en,
    input logic [7:0] fast_osc_trim,
    input logic [7:0] slow_osc_trim
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // four cycles covers the output register; the enables mask edges after the pin synchroniser
    sequence s_fast_off;
        (!osc_enable[0])[*4];
    endsequence
    sequence s_ls_off;
        (!osc_enable[3])[*4];
    endsequence
    a_src_hold: assert property (
        !($past(io_we) && $past(io_addr) == scm_pkg::ADDR_SRC_CTRL) |-> $stable(osc_enable))
        else $error("source enables changed without a write");
    a_div_hold: assert property (
        !($past(io_we) && $past(io_addr) == scm_pkg::ADDR_DIVIDER) |-> $stable(sys_clk_out_en))
        else $error("divider output bits changed without a write");
    a_trim_hold: assert property (
        $past(rstn, 2) && $past(rstn) && !$past(cfg_reload) && !$past(io_we)
        |-> $stable(fast_osc_trim) && $stable(slow_osc_trim))
        else $error("trim changed without write or reload");
    a_core_sleep: assert property (sleep_req |-> !core_clk_en)
        else $error("core enable pulsed during sleep");
    a_peri_halt: assert property (peri_halt |-> !peri_clk_en)
        else $error("peripheral enable pulsed while halted");
    a_core_peri: assert property (
        !sleep_req && !peri_halt |-> core_clk_en == peri_clk_en)
        else $error("core and peripheral enables differ");
    a_flash_pulse: assert property (flash_if_clock |=> !flash_if_clock)
        else $error("flash tick longer than one cycle");
    a_flash_gate: assert property (s_fast_off |-> !flash_if_clock)
        else $error("flash tick with fast oscillator off");
    a_async_gate: assert property (s_ls_off |-> !async_timer_tick)
        else $error("timer tick with low-speed crystal off");
endmodule

bind scm_clock_manager scm_chk i_chk (.mclk, .rstn, .io_addr, .io_we, .sleep_req, .peri_halt,
    .cfg_reload, .core_clk_en, .peri_clk_en, .flash_if_clock, .async_timer_tick, .osc_enable,
    .sys_clk_out_en, .fast_osc_trim, .slow_osc_trim);

// ### scm_tb.sv
// self-checking bench for the system clock manager
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SC = scm_pkg::ADDR_SRC_CTRL;
    localparam logic [7:0] DV = scm_pkg::ADDR_DIVIDER;
    localparam logic [7:0] FT = scm_pkg::ADDR_FAST_TRIM;
    localparam logic [7:0] ST = scm_pkg::ADDR_SLOW_TRIM;
    localparam logic [7:0] FTRIM = 8'h5a;
    localparam logic [7:0] STRIM = 8'hc3;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic io_we = 1'b0;
    logic io_re = 1'b0;
    logic fast_rc_osc = 1'b0;
    logic slow_rc_osc = 1'b0;
    logic hs_xtal = 1'b0;
    logic ls_xtal = 1'b0;
    logic sleep_req = 1'b0;
    logic peri_halt = 1'b0;
    logic cfg_reload = 1'b0;
    logic [7:0] io_rdata;
    logic core_clk_en, peri_clk_en, flash_if_clock, async_timer_tick, watchdog_clock;
    logic [3:0] osc_enable;
    logic [1:0] sys_clk_out_en;
    logic [7:0] fast_osc_trim, slow_osc_trim;
    int fail_count = 0;
    int check_count = 0;
    int n_core, n_peri, n_flash, n_wdt, n_async;

    always #20 mclk = ~mclk;

    // every oscillator pin is driven so each main source can really be selected
    scm_clock_manager i_dut (.mclk, .rstn, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata,
        .fast_rc_osc, .slow_rc_osc, .hs_xtal, .ls_xtal, .sleep_req, .peri_halt,
        .cfg_fast_trim(FTRIM), .cfg_slow_trim(STRIM), .cfg_reload, .core_clk_en,
        .peri_clk_en, .flash_if_clock, .async_timer_tick, .watchdog_clock, .osc_enable,
        .sys_clk_out_en, .fast_osc_trim, .slow_osc_trim);

    always @(posedge mclk) begin
        n_core += core_clk_en;
        n_peri += peri_clk_en;
        n_flash += flash_if_clock;
        n_wdt += watchdog_clock;
        n_async += async_timer_tick;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // strobes stay low for a cycle after each access, so calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_we = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge mclk);
        io_we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        io_re = 1'b1;
        io_addr = a;
        @(negedge mclk);
        io_re = 1'b0;
        chk(io_rdata, e);
    endtask

    task automatic prot(input logic [7:0] a, input logic [7:0] d);
        wr(a, (a == SC) ? 8'h80 : scm_pkg::DIV_OPEN_VALUE);
        wr(a, d);
    endtask

    // oscillator edges every four cycles so the synchroniser sees each one
    task automatic osc(input int n);
        n_core = 0;
        n_peri = 0;
        n_flash = 0;
        n_wdt = 0;
        n_async = 0;
        repeat (n) begin
            idle(1);
            {fast_rc_osc, slow_rc_osc, hs_xtal, ls_xtal} = 4'hf;
            idle(2);
            {fast_rc_osc, slow_rc_osc, hs_xtal, ls_xtal} = 4'h0;
            idle(1);
        end
        idle(8);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end

    initial begin
        idle(12);
        rstn = 1'b1;
        rd(SC, 8'h13);
        rd(DV, 8'h03);
        rd(FT, FTRIM);
        rd(ST, STRIM);
        rd(8'h00, 8'h00);
        chk(osc_enable, 4'h3);
        wr(SC, 8'h1f);
        rd(SC, 8'h13);
        wr(SC, 8'h80);
        idle(4);
        wr(SC, 8'h1f);
        rd(SC, 8'h1f);
        chk(osc_enable, 4'hf);
        wr(SC, 8'h80);
        idle(5);
        wr(SC, 8'h13);
        rd(SC, 8'h1f);
        prot(SC, 8'h5f);
        wr(SC, 8'h13);
        rd(SC, 8'h5f);
        for (int s = 0; s < 4; s++) begin
            prot(SC, {1'b0, 2'(s), 5'h1f});
            rd(SC, {1'b0, 2'(s), 5'h1f});
        end
        prot(SC, 8'h1f);
        wr(DV, 8'h80);
        idle(2);
        wr(DV, 8'h05);
        rd(DV, 8'h05);
        wr(DV, 8'h80);
        idle(3);
        wr(DV, 8'h07);
        rd(DV, 8'h05);
        wr(DV, 8'h81);
        wr(DV, 8'h02);
        rd(DV, 8'h05);
        prot(DV, 8'h88);
        // refused write leaves the window open, so the change bit still reads 1
        rd(DV, 8'h85);
        prot(DV, 8'h09);
        rd(DV, 8'h05);
        prot(DV, 8'h68);
        rd(DV, 8'h68);
        chk(sys_clk_out_en, 2'h3);
        for (int c = 0; c <= 8; c++) begin
            prot(DV, 8'(c));
            rd(DV, 8'(c));
        end
        prot(DV, 8'h00);
        wr(FT, 8'ha5);
        wr(ST, 8'h3c);
        rd(FT, 8'ha5);
        rd(ST, 8'h3c);
        chk(fast_osc_trim, 8'ha5);
        chk(slow_osc_trim, 8'h3c);
        cfg_reload = 1'b1;
        idle(1);
        cfg_reload = 1'b0;
        rd(FT, FTRIM);
        rd(ST, STRIM);
        sleep_req = 1'b1;
        osc(64);
        chk(n_core, 0);
        chk(n_peri != 0, 1);
        chk(n_flash, 64 / scm_pkg::FLASH_IF_DIV);
        chk(n_wdt, 64);
        chk(n_async, 64);
        sleep_req = 1'b0;
        prot(SC, 8'h07);
        osc(64);
        chk(n_wdt, 64 / scm_pkg::WDT_FAST_DIV);
        chk(n_async, 0);
        chk(n_core, 64);
        chk(n_core, n_peri);
        // watchdog moves to slow rc in the same write that selects the crystal, before fast rc is turned off
        prot(SC, 8'h37);
        prot(SC, 8'h36);
        chk(osc_enable, 4'h6);
        peri_halt = 1'b1;
        osc(40);
        chk(n_core, 40);
        chk(n_peri, 0);
        chk(n_flash, 0);
        chk(n_wdt, 40);
        chk(n_async, 0);
        peri_halt = 1'b0;
        wrap_up();
    end
endmodule
